/* File: failsafe_pkg.sv */
// Contract
// - Time-out without all-ones exit write enters fail-safe
// - Bits 3:1 pick one of eight time-outs
// - Fail-safe entry loads stored configuration
// - Fail-safe: only control register writable
// - Exit sequence done: normal, PWM, writes open
// - Leaving fail-safe keeps loaded register contents
// - Bit 7 reads fail-safe status
// - Bit 0 reads configuration mode status
// - Non-volatile access state halts time-out timer
// - Non-volatile use: outputs off, writes ignored; control writes still update bits 3:1
// - Non-volatile use left only by reset
// - Fail-silent latches; no automatic recovery
// - Normal and access: registers, PWM, full access
// - Fail-safe channel follows two-bit override code
package failsafe_pkg;

  localparam int CLK_MHZ = 100;
  localparam int TO_BASE_US = 16;
  localparam int TO_BASE_CYC = TO_BASE_US * CLK_MHZ;

  localparam logic [6:0] CTRL_ADDR = 7'h33;
  localparam int STATUS_BIT = 7;
  localparam int EXIT_MSB = 6;
  localparam int EXIT_LSB = 4;
  localparam int TSEL_MSB = 3;
  localparam int TSEL_LSB = 1;
  localparam int CFG_BIT = 0;
  localparam logic [2:0] TSEL_RESET = 3'h0;

  localparam logic [2:0] EXIT_REFRESH = 3'h7;
  localparam logic [2:0] EXIT_STEP1 = 3'h1;
  localparam logic [2:0] EXIT_STEP2 = 3'h2;
  localparam logic [2:0] EXIT_STEP3 = 3'h4;

  localparam logic [1:0] OVR_OFF = 2'h0;
  localparam logic [1:0] OVR_ON = 2'h2;
  localparam int OVR_LSB = 1;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_FAILSAFE = 2'b01,
    ST_NV_ACCESS = 2'b10,
    ST_NV_USE = 2'b11
  } op_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_GOT1 = 2'b01,
    SEQ_GOT2 = 2'b10
  } exit_seq_t;

endpackage

/* File: failsafe_timeout_timer.sv */
`timescale 1ns/1ps
module failsafe_timeout_timer
  import failsafe_pkg::*;
#(
  parameter int BASE_CYC = TO_BASE_CYC,
  parameter int CW = 20
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control
  input wire logic run,
  input wire logic refresh,
  input wire logic [2:0] sel,
  // Result
  output logic expired
);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] limit;

  // Setting k lasts (k+1) base periods
  function automatic logic [CW-1:0] limit_of(input logic [2:0] s);
    limit_of = CW'((int'(s) + 1) * BASE_CYC - 1);
  endfunction

  assign limit = limit_of(sel);

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk)
  begin
    if (srst || refresh || !run)
    begin
      cnt_r <= '0;
    end
    else if (cnt_r < limit)
    begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      expired <= 1'b0;
    end
    else
    begin
      expired <= run && !refresh && (cnt_r == limit);
    end
  end

endmodule

/* File: limp_home_failsafe_controller.sv */
`timescale 1ns/1ps
module limp_home_failsafe_controller
  import failsafe_pkg::*;
#(
  parameter int NCH = 3,
  parameter int BASE_CYC = TO_BASE_CYC
)
(
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic srst,
  // Decoded serial register writes
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // Stored configuration and state requests
  input wire logic [7:0] channel_override_code,
  input wire logic nonvolatile_store_access_req,
  input wire logic nv_use_req,
  input wire logic fail_silent_evt,
  // Channel PWM inputs
  input wire logic [NCH-1:0] pwm_in,
  // Register read-back
  output logic [7:0] ctrl_rdata,
  // Register bank steering
  output logic load_stored_cfg,
  output logic other_writes_locked,
  output logic writes_no_effect,
  output logic nv_rw_permitted,
  // Channel drive and status
  output logic [NCH-1:0] ch_on,
  output logic fail_silent,
  output logic in_failsafe
);

  op_state_t state_r;
  exit_seq_t seq_r;
  logic [2:0] tsel_r;
  logic [1:0] ovr_r [NCH];
  logic ctrl_wr;
  logic [2:0] exit_val;
  logic expired;
  logic exit_done;

  assign ctrl_wr = reg_wr && (reg_addr == CTRL_ADDR);
  assign exit_val = reg_wdata[EXIT_MSB:EXIT_LSB];
  assign exit_done = (state_r == ST_FAILSAFE) && ctrl_wr &&
                     (seq_r == SEQ_GOT2) && (exit_val == EXIT_STEP3);

  // Channel action for one override code
  function automatic logic ovr_drive(input logic [1:0] code,
                                     input logic pwm);
    if (code == OVR_OFF)
    begin
      ovr_drive = 1'b0;
    end
    else if (code == OVR_ON)
    begin
      ovr_drive = 1'b1;
    end
    else
    begin
      ovr_drive = pwm;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Time-out timer, runs in normal operation only
  failsafe_timeout_timer #(
    .BASE_CYC(BASE_CYC),
    .CW(20)
  ) u_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(state_r == ST_NORMAL),
    .refresh(ctrl_wr && (exit_val == EXIT_REFRESH)),
    .sel(tsel_r),
    .expired(expired)
  );

  //////////////////////////////////////////////////////////////////////////
  // Time-out selection: whole register written at once
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      tsel_r <= TSEL_RESET;
    end
    else if (ctrl_wr)
    begin
      tsel_r <= reg_wdata[TSEL_MSB:TSEL_LSB];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Operating state
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_r <= ST_NORMAL;
    end
    else
    begin
      unique case (state_r)
        ST_NORMAL:
        begin
          if (nonvolatile_store_access_req)
          begin
            state_r <= ST_NV_ACCESS;
          end
          else if (expired)
          begin
            state_r <= ST_FAILSAFE;
          end
        end
        ST_FAILSAFE:
        begin
          if (exit_done)
          begin
            state_r <= ST_NORMAL;
          end
        end
        ST_NV_ACCESS:
        begin
          if (nv_use_req)
          begin
            state_r <= ST_NV_USE;
          end
        end
        ST_NV_USE:
        begin
          state_r <= ST_NV_USE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Exit sequence tracking
  always_ff @(posedge ref_clk)
  begin
    if (srst || state_r != ST_FAILSAFE)
    begin
      seq_r <= SEQ_IDLE;
    end
    else if (ctrl_wr)
    begin
      if (exit_val == EXIT_STEP1)
      begin
        seq_r <= SEQ_GOT1;
      end
      else if (seq_r == SEQ_GOT1 && exit_val == EXIT_STEP2)
      begin
        seq_r <= SEQ_GOT2;
      end
      else
      begin
        seq_r <= SEQ_IDLE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Stored configuration load on fail-safe entry
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      load_stored_cfg <= 1'b0;
    end
    else
    begin
      // One pulse only; nothing reloads on exit
      load_stored_cfg <= (state_r == ST_NORMAL) &&
                         !nonvolatile_store_access_req &&
                         expired;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ovr_r[i] <= OVR_OFF;
      end
    end
    else if (state_r == ST_NORMAL && !nonvolatile_store_access_req &&
             expired)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ovr_r[i] <= channel_override_code[OVR_LSB+2*i +: 2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fail-silent latch
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      fail_silent <= 1'b0;
    end
    else if (fail_silent_evt)
    begin
      fail_silent <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Access steering
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      other_writes_locked <= 1'b0;
      writes_no_effect <= 1'b0;
      nv_rw_permitted <= 1'b0;
      in_failsafe <= 1'b0;
    end
    else
    begin
      // Next-state view so locks track the state register
      other_writes_locked <= (state_r == ST_FAILSAFE && !exit_done) ||
                             (state_r == ST_NORMAL && expired &&
                              !nonvolatile_store_access_req);
      writes_no_effect <= (state_r == ST_NV_USE) ||
                          (state_r == ST_NV_ACCESS && nv_use_req);
      nv_rw_permitted <= (state_r == ST_NV_USE) ||
                         (state_r == ST_NV_ACCESS && nv_use_req);
      in_failsafe <= (state_r == ST_FAILSAFE && !exit_done) ||
                     (state_r == ST_NORMAL && expired &&
                      !nonvolatile_store_access_req);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Channel drive
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ch_on <= '0;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (fail_silent || state_r == ST_NV_USE)
        begin
          ch_on[i] <= 1'b0;
        end
        else if (state_r == ST_FAILSAFE)
        begin
          ch_on[i] <= ovr_drive(ovr_r[i], pwm_in[i]);
        end
        else
        begin
          ch_on[i] <= pwm_in[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control register read-back; exit field reads zero
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrl_rdata <= 8'h00;
    end
    else
    begin
      ctrl_rdata[STATUS_BIT] <= (state_r == ST_FAILSAFE);
      ctrl_rdata[EXIT_MSB:EXIT_LSB] <= 3'h0;
      ctrl_rdata[TSEL_MSB:TSEL_LSB] <= tsel_r;
      ctrl_rdata[CFG_BIT] <= (state_r == ST_NV_ACCESS) ||
                             (state_r == ST_NV_USE);
    end
  end

endmodule

/* File: limp_home_failsafe_controller_asserts.sv */
`timescale 1ns/1ps
module limp_home_failsafe_controller_asserts
  import failsafe_pkg::*;
#(
  parameter int NCH = 3
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Watched outputs
  input wire logic [7:0] ctrl_rdata,
  input wire logic load_stored_cfg,
  input wire logic other_writes_locked,
  input wire logic writes_no_effect,
  input wire logic nv_rw_permitted,
  input wire logic [NCH-1:0] ch_on,
  input wire logic fail_silent,
  input wire logic in_failsafe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  property p_load;
    $rose(in_failsafe) |-> load_stored_cfg ##1 !load_stored_cfg;
  endproperty
  a_load: assert property (p_load) else $error("bad load");
  property p_keep;
    $fell(in_failsafe) |-> !load_stored_cfg;
  endproperty
  a_keep: assert property (p_keep) else $error("reload");
  property p_lock;
    other_writes_locked == in_failsafe;
  endproperty
  a_lock: assert property (p_lock) else $error("bad lock");
  property p_status;
    ctrl_rdata[STATUS_BIT] == $past(in_failsafe);
  endproperty
  a_status: assert property (p_status) else $error("bit7");
  property p_nvuse;
    writes_no_effect |=> writes_no_effect && ch_on == '0;
  endproperty
  a_nvuse: assert property (p_nvuse) else $error("nv use");
  property p_nvrw;
    nv_rw_permitted == writes_no_effect;
  endproperty
  a_nvrw: assert property (p_nvrw) else $error("nv rw");
  property p_cfg;
    writes_no_effect |=> ctrl_rdata[CFG_BIT];
  endproperty
  a_cfg: assert property (p_cfg) else $error("bit0");
  property p_silent;
    fail_silent |=> fail_silent && ch_on == '0;
  endproperty
  a_silent: assert property (p_silent) else $error("silent");
  property p_nofs;
    ctrl_rdata[CFG_BIT] |-> !$rose(in_failsafe);
  endproperty
  a_nofs: assert property (p_nofs) else $error("nv timeout");
endmodule
bind limp_home_failsafe_controller limp_home_failsafe_controller_asserts
  #(.NCH(NCH)) u_chk (.ref_clk(ref_clk), .srst(srst),
  .ctrl_rdata(ctrl_rdata), .load_stored_cfg(load_stored_cfg),
  .other_writes_locked(other_writes_locked),
  .writes_no_effect(writes_no_effect), .nv_rw_permitted(nv_rw_permitted),
  .ch_on(ch_on), .fail_silent(fail_silent), .in_failsafe(in_failsafe));

/* File: limp_home_failsafe_controller_bench.sv */
`timescale 1ns/1ps
module limp_home_failsafe_controller_bench;
  import failsafe_pkg::*;
  localparam int BC = 4;
  logic ref_clk;
  logic srst = 1'b1;
  logic reg_wr;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] ovr = 8'h00;
  logic nva_req = 1'b0;
  logic nvu_req = 1'b0;
  logic fs_evt = 1'b0;
  logic [2:0] pwm_in = 3'b011;
  logic [7:0] ctrl_rdata;
  logic load_stored_cfg;
  logic other_writes_locked;
  logic writes_no_effect;
  logic nv_rw_permitted;
  logic [2:0] ch_on;
  logic fail_silent;
  logic in_failsafe;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  mcu_model u_mcu (.ref_clk(ref_clk), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  limp_home_failsafe_controller #(.NCH(3), .BASE_CYC(BC)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .channel_override_code(ovr), .nonvolatile_store_access_req(nva_req),
    .nv_use_req(nvu_req), .fail_silent_evt(fs_evt), .pwm_in(pwm_in),
    .ctrl_rdata(ctrl_rdata), .load_stored_cfg(load_stored_cfg),
    .other_writes_locked(other_writes_locked),
    .writes_no_effect(writes_no_effect), .nv_rw_permitted(nv_rw_permitted),
    .ch_on(ch_on), .fail_silent(fail_silent), .in_failsafe(in_failsafe));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset();
    srst = 1'b1;
    tick(3);
    srst = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_timeout(input logic [2:0] sel);
    int n;
    ovr = {1'b0, 2'b10, 2'b00, sel[0] ? 2'b01 : 2'b11, 1'b0};
    u_mcu.ctrl(EXIT_REFRESH, sel);
    n = 0;
    while (in_failsafe !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    chk("entry_min", 8'h01, n >= (sel + 1) * BC);
    chk("entry_max", 8'h01, n <= (sel + 1) * BC + 2);
    chk("locked", 8'h01, other_writes_locked);
    chk("load", 8'h01, load_stored_cfg);
    tick(1);
    chk("status", {1'b1, 3'h0, sel, 1'b0}, ctrl_rdata);
    chk("override", 8'h05, ch_on);
    chk("load_once", 8'h00, load_stored_cfg);
    // Low PWM on forced-on, high on forced-off, low on follow
    pwm_in = 3'h2;
    tick(1);
    chk("override_pwm", 8'h04, ch_on);
    pwm_in = 3'h3;
    u_mcu.ctrl(EXIT_STEP1, sel);
    u_mcu.ctrl(EXIT_STEP2, sel);
    u_mcu.wr(7'h02, 8'h5A);
    u_mcu.ctrl(EXIT_REFRESH, sel);
    u_mcu.ctrl(EXIT_STEP3, sel);
    tick(1);
    chk("no_exit", 8'h01, in_failsafe);
    u_mcu.exit_seq(3'h7);
    tick(1);
    chk("exited", 8'h00, {in_failsafe, other_writes_locked});
    tick(1);
    chk("pwm", pwm_in, ch_on);
    chk("normal", 8'h0E, ctrl_rdata);
    $display("test timeout %0d done", sel);
  endtask
  task automatic t_silent();
    fs_evt = 1'b1;
    tick(1);
    fs_evt = 1'b0;
    tick(2);
    chk("silent", 8'h08, {fail_silent, ch_on});
    u_mcu.ctrl(EXIT_REFRESH, 3'h7);
    tick(20);
    chk("silent_kept", 8'h08, {fail_silent, ch_on});
    do_reset();
    $display("test silent done");
  endtask
  task automatic t_nv();
    nva_req = 1'b1;
    tick(1);
    nva_req = 1'b0;
    tick(2);
    chk("cfg", 8'h01, ctrl_rdata);
    tick(40);
    chk("no_timeout", 8'h00, in_failsafe);
    chk("access_pwm", pwm_in, ch_on);
    nvu_req = 1'b1;
    tick(1);
    nvu_req = 1'b0;
    tick(2);
    chk("use", 8'h08, {writes_no_effect, ch_on});
    chk("nv_rw", 8'h01, nv_rw_permitted);
    u_mcu.ctrl(EXIT_REFRESH, 3'h5);
    tick(2);
    chk("use_kept", 8'h01, writes_no_effect);
    do_reset();
    chk("use_left", 8'h00, writes_no_effect);
    $display("test nv done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    do_reset();
    for (int s = 0; s < 8; s++)
      t_timeout(s[2:0]);
    t_silent();
    t_nv();
    tally_and_finish();
  end
endmodule

/* File: mcu_model.sv */
`timescale 1ns/1ps
module mcu_model
  import failsafe_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Decoded register write
  output logic reg_wr,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    // Released payload shows the inverse of its last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic ctrl(input logic [2:0] ex, input logic [2:0] sel);
    wr(CTRL_ADDR, {1'b0, ex, sel, 1'b0});
  endtask
  task automatic exit_seq(input logic [2:0] sel);
    ctrl(EXIT_STEP1, sel);
    ctrl(EXIT_STEP2, sel);
    ctrl(EXIT_STEP3, sel);
  endtask
endmodule
